// *** drive_fault_error_detect.sv ***
/*
  Drive fault and error detection: common fault latch, per-error indication
  latches, no-servo-tracks and seek-error latches, write protect on low speed.
  Assumes all monitor inputs are synchronous to clk; rst_b is power-down.
*/
// Implementation choices: the plain strobed port and the placing of the registers.
// Behaviour
// - A set fault latch drives fault line, panel lamp, drops ready, inhibits write, load.
// - Fault latch clears on operator, controller or maintenance clear, once errors are gone.
// - Each fault also sets its own stored indication latch.
// - Indication latches clear only on power-down or maintenance clear.
// - Write fault from driver output, driver current, +22 V, or no write data.
// - More than one head selected raises a fault.
// - Read gate and write gate together raise a fault.
// - Read or write gate while off cylinder raises a fault.
// - Any monitored supply low raises a voltage fault.
// - Low voltage or slow spindle: inhibit write, write protect, retract; slow spindle alone sets no fault latch.
// - No servo dibits 350 ms after load start sets no-servo latch, lamp, unload.
// - No-servo latch blocks loads; clears on operator, controller or maintenance clear, even with errors present.
// - Seek not on cylinder within 500 ms sets seek-error latch.
// - Either end-of-travel sensor sets seek-error latch.
// - Seek above cylinder 410, or 822 on large variant, sets seek-error latch.
// - Seek-error latch drives seek-error line and blocks further seeks.
// - A return-to-zero seek command clears the seek-error latch.
`timescale 1ns/1ps
module drive_fault_error_detect
#(
  parameter int unsigned SERVO_CYC = fault_pkg::SERVO_LIMIT_CYC,
  parameter int unsigned SEEK_CYC  = fault_pkg::SEEK_LIMIT_CYC
)
(
  // Clock and power-down reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Write path and supply monitors
  input  wire fault_pkg::write_mon_type write_mon,
  input  wire logic                     supply_low,
  input  wire logic                     speed_low,
  input  wire logic [18:0]              head_sel,
  // Controller gates and commands
  input  wire logic                     read_gate,
  input  wire logic                     write_gate,
  input  wire logic                     seek_start,
  input  wire logic [9:0]               seek_cyl,
  input  wire logic                     rtz_cmd,
  input  wire logic                     large_variant,
  // Positioner and servo status
  input  wire logic                     on_cylinder,
  input  wire logic                     travel_limit_sensed,
  input  wire logic                     load_start,
  input  wire logic                     dibit_seen,
  // Clears
  input  wire fault_pkg::clear_src_type clear_src,
  // Register port
  input  wire logic [1:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [7:0]                    reg_rdata,
  output logic                          irq,
  // Controller and panel outputs
  output logic                          fault_line,
  output logic                          fault_lamp,
  output logic                          unit_ready,
  output logic                          seek_error_line,
  output logic                          write_protect,
  output logic                          write_inhibit,
  output logic                          load_inhibit,
  output logic                          seek_inhibit,
  output logic                          emergency_retract,
  output logic                          home_retract_logic,
  output logic                          seek_accept
);

  // ----------------------------------------------------------------
  // Error detection
  // ----------------------------------------------------------------
  wire multi_sel;
  wire servo_expired;
  wire seek_expired;
  wire [fault_pkg::ERR_N-1:0] err_now;
  wire any_err;
  wire gen_clear;
  wire fault_clear;
  wire cyl_limit_hit;
  wire seek_err_set;
  wire seek_go;
  wire load_go;

  head_count #(.HEADS(19)) u_heads
  (
    .head_sel  (head_sel),
    .multi_sel (multi_sel)
  );

  assign err_now[fault_pkg::ERR_WRITE]  = |write_mon;
  assign err_now[fault_pkg::ERR_HEAD]   = multi_sel;
  assign err_now[fault_pkg::ERR_RW]     = read_gate & write_gate;
  assign err_now[fault_pkg::ERR_OFFCYL] = (read_gate | write_gate)
                                        & ~on_cylinder;
  assign err_now[fault_pkg::ERR_VOLT]   = supply_low;
  assign any_err = |err_now;

  // Clear only accepted once every error has gone away
  assign gen_clear   = clear_src.operator_sw | clear_src.ctrl_clear | clear_src.maint_sw;
  assign fault_clear = gen_clear & ~any_err;

  // ----------------------------------------------------------------
  // Common fault latch and indication latches
  // ----------------------------------------------------------------
  logic                       fault_q;
  logic [fault_pkg::ERR_N-1:0] ind_q;
  logic [fault_pkg::ERR_N-1:0] ind_d;
  logic                       servo_q;
  logic                       servo_exp_q;
  logic                       seek_err_q;

  assign ind_d = clear_src.maint_sw ? (ind_q & ~ind_q) | err_now
                                    : ind_q | err_now;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fault_q <= 1'b0;
      ind_q   <= fault_pkg::ERR_RESET;
    end
    else
    begin
      fault_q <= any_err | (fault_q & ~fault_clear);
      ind_q   <= ind_d;
    end
  end

  // ----------------------------------------------------------------
  // No servo tracks
  // ----------------------------------------------------------------
  assign load_go = load_start & ~servo_q & ~fault_q;

  fault_timer #(.LIMIT(SERVO_CYC)) u_servo_tmr
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .start   (load_go),
    .stop    (dibit_seen),
    .expired (servo_expired)
  );

  // Set only on the expiry edge: the timer stays parked in its done state,
  // and a level set would undo every clear until the next load
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      servo_q     <= 1'b0;
      servo_exp_q <= 1'b0;
    end
    else
    begin
      servo_exp_q <= servo_expired;
      servo_q     <= (servo_expired & ~servo_exp_q & ~dibit_seen)
                   | (servo_q & ~gen_clear);
    end
  end

  // ----------------------------------------------------------------
  // Seek error
  // ----------------------------------------------------------------
  assign seek_go       = seek_start & ~seek_err_q;
  assign cyl_limit_hit = seek_start & (seek_cyl > (large_variant ?
                         fault_pkg::CYL_MAX_LARGE : fault_pkg::CYL_MAX_SMALL));

  fault_timer #(.LIMIT(SEEK_CYC)) u_seek_tmr
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .start   (seek_go),
    .stop    (on_cylinder & ~seek_go),
    .expired (seek_expired)
  );

  assign seek_err_set = (seek_expired & ~on_cylinder)
                      | travel_limit_sensed
                      | cyl_limit_hit;

  // Set wins over the return-to-zero clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      seek_err_q <= 1'b0;
    else
      seek_err_q <= seek_err_set | (seek_err_q & ~rtz_cmd);
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fault_line         = fault_q;
  assign fault_lamp         = fault_q | servo_q;
  assign unit_ready         = ~fault_q;
  assign write_inhibit      = fault_q | supply_low | speed_low;
  assign load_inhibit       = fault_q | servo_q;
  assign write_protect      = supply_low | speed_low;
  assign emergency_retract  = supply_low | speed_low;
  assign home_retract_logic = servo_q;
  assign seek_error_line    = seek_err_q;
  assign seek_inhibit       = seek_err_q;
  assign seek_accept        = seek_go;

  // ----------------------------------------------------------------
  // Register port and interrupt
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK   = 2'h1;
  localparam logic [1:0] ADDR_IND    = 2'h2;
  localparam logic [1:0] ADDR_LIVE   = 2'h3;

  logic [7:0] stat_q;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic [7:0] prev_q;
  wire  [7:0] ev_level;
  wire  [7:0] ev_rise;
  wire        rd_status;
  wire  [7:0] rd_mux;

  assign ev_level  = {3'h0, speed_low | supply_low, seek_err_q, servo_q, 1'b0, fault_q};
  assign ev_rise   = ev_level & ~prev_q;
  assign rd_status = reg_rd & (reg_addr == ADDR_STATUS);
  assign rd_mux    = (reg_addr == ADDR_STATUS) ? stat_q :
                     (reg_addr == ADDR_MASK)   ? mask_q :
                     (reg_addr == ADDR_IND)    ? {3'h0, ind_q} : ev_level;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_q  <= 8'h00;
      mask_q  <= 8'h00;
      rdata_q <= 8'h00;
      prev_q  <= 8'h00;
    end
    else
    begin
      prev_q  <= ev_level;
      stat_q  <= ev_rise | (stat_q & ~{8{rd_status}});
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      if (reg_wr && reg_addr == ADDR_MASK)
        mask_q <= reg_wdata;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fault_outputs: assert property (@(posedge clk) disable iff (!rst_b)
    fault_q |-> (fault_line && !unit_ready && write_inhibit && load_inhibit))
    else $error("fault latch without its effects");
  a_fault_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (fault_q && any_err) |=> fault_q)
    else $error("fault latch cleared while error present");
  a_ind_set: assert property (@(posedge clk) disable iff (!rst_b)
    err_now[fault_pkg::ERR_RW] |=> (ind_q[fault_pkg::ERR_RW] && fault_q))
    else $error("indication latch missed");
  a_ind_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (!clear_src.maint_sw && ind_q[fault_pkg::ERR_WRITE]) |=> ind_q[fault_pkg::ERR_WRITE])
    else $error("indication latch lost");
  a_write_fault: assert property (@(posedge clk) disable iff (!rst_b)
    write_mon.v22_low |=> ind_q[fault_pkg::ERR_WRITE])
    else $error("write fault not stored");
  a_multi_head: assert property (@(posedge clk) disable iff (!rst_b)
    (head_sel[0] && head_sel[18]) |=> fault_q)
    else $error("multiple head select missed");
  a_offcyl_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (read_gate && !on_cylinder) |=> ind_q[fault_pkg::ERR_OFFCYL])
    else $error("off-cylinder gate missed");
  a_speed_prot: assert property (@(posedge clk) disable iff (!rst_b)
    (speed_low && !any_err && !fault_q) |-> (write_protect && emergency_retract) ##1 !fault_q)
    else $error("low speed handling wrong");
  a_servo_block: assert property (@(posedge clk) disable iff (!rst_b)
    servo_q |-> (!load_go && home_retract_logic && fault_lamp))
    else $error("load allowed with no servo");
  a_travel_limit: assert property (@(posedge clk) disable iff (!rst_b)
    travel_limit_sensed |=> (seek_error_line && seek_inhibit))
    else $error("end of travel missed");
  a_cyl_range: assert property (@(posedge clk) disable iff (!rst_b)
    (seek_start && !large_variant && seek_cyl == 10'h19b) |=> seek_err_q)
    else $error("cylinder range missed");
  a_volt_fault: assert property (@(posedge clk) disable iff (!rst_b)
    supply_low |=> (fault_q && ind_q[fault_pkg::ERR_VOLT]))
    else $error("voltage fault missed");
  a_seek_block: assert property (@(posedge clk) disable iff (!rst_b)
    seek_err_q |-> (!seek_accept && seek_error_line))
    else $error("seek accepted during seek error");
  a_rtz_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (rtz_cmd && !seek_err_set) |=> !seek_err_q)
    else $error("rtz did not clear seek error");

endmodule : drive_fault_error_detect

// *** fault_pkg.sv ***
/*
  Constants and carrier types for the drive fault and error detection block.
  Assumes a 40 MHz logic clock and synchronous monitor inputs.
*/
package fault_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned SERVO_LIMIT_MS  = 350;
  localparam int unsigned SEEK_LIMIT_MS   = 500;
  localparam int unsigned SERVO_LIMIT_CYC = SERVO_LIMIT_MS * (CLK_HZ / 1000);
  localparam int unsigned SEEK_LIMIT_CYC  = SEEK_LIMIT_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W         = 25;

  // ----------------------------------------------------------------
  // Cylinder limits
  // ----------------------------------------------------------------
  localparam logic [9:0] CYL_MAX_SMALL = 10'h19a;
  localparam logic [9:0] CYL_MAX_LARGE = 10'h336;

  // ----------------------------------------------------------------
  // Per-error indication indices
  // ----------------------------------------------------------------
  localparam int unsigned ERR_N      = 5;
  localparam int unsigned ERR_WRITE  = 0;
  localparam int unsigned ERR_HEAD   = 1;
  localparam int unsigned ERR_RW     = 2;
  localparam int unsigned ERR_OFFCYL = 3;
  localparam int unsigned ERR_VOLT   = 4;

  localparam logic [4:0] ERR_RESET = 5'h00;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_RUN  = 2'b01,
    TMR_DONE = 2'b11
  } tmr_state_type;

  // Write path health, all high when a problem is seen
  typedef struct packed {
    logic drv_out_low;
    logic drv_cur_low;
    logic v22_low;
    logic no_data_trans;
  } write_mon_type;

  // Operator, controller and maintenance clears
  typedef struct packed {
    logic operator_sw;
    logic ctrl_clear;
    logic maint_sw;
  } clear_src_type;

endpackage : fault_pkg

// *** fault_timer.sv ***
/*
  Restartable timeout counter: counts while armed, flags when limit reached.
  Assumes start and stop are single-cycle or level signals on clk.
*/
`timescale 1ns/1ps
module fault_timer
#(
  parameter int unsigned LIMIT = 1000
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control
  input  wire logic start,
  input  wire logic stop,
  // Result
  output logic      expired
);

  fault_pkg::tmr_state_type      state_q;
  fault_pkg::tmr_state_type      state_d;
  logic [fault_pkg::TIMER_W-1:0] count_q;
  logic [fault_pkg::TIMER_W-1:0] count_d;
  wire                           at_limit;

  assign at_limit = (count_q == fault_pkg::TIMER_W'(LIMIT - 1));
  assign expired  = (state_q == fault_pkg::TMR_DONE);

  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    unique case (state_q)
      fault_pkg::TMR_IDLE:
      begin
        count_d = '0;
        if (start)
          state_d = fault_pkg::TMR_RUN;
      end
      fault_pkg::TMR_RUN:
      begin
        count_d = count_q + fault_pkg::TIMER_W'(1);
        if (start)
          count_d = '0;
        else if (stop)
          state_d = fault_pkg::TMR_IDLE;
        else if (at_limit)
          state_d = fault_pkg::TMR_DONE;
      end
      fault_pkg::TMR_DONE:
      begin
        count_d = '0;
        if (start)
          state_d = fault_pkg::TMR_RUN;
        else if (stop)
          state_d = fault_pkg::TMR_IDLE;
      end
      default:
        state_d = fault_pkg::TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= fault_pkg::TMR_IDLE;
      count_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

endmodule : fault_timer

// *** head_count.sv ***
/*
  Flags more than one head select output active at once.
  Assumes the head select vector is synchronous to clk.
*/
`timescale 1ns/1ps
module head_count
#(
  parameter int unsigned HEADS = 19
)
(
  // Head select monitor
  input  wire logic [HEADS-1:0] head_sel,
  // Result
  output logic                  multi_sel
);

  logic [HEADS:0] seen;
  logic [HEADS:0] dup;

  assign seen[0] = 1'b0;
  assign dup[0]  = 1'b0;

  // Running "one seen" and "two seen" across the vector
  for (genvar i = 0; i < HEADS; i++)
  begin : g_bit
    assign seen[i+1] = seen[i] | head_sel[i];
    assign dup[i+1]  = dup[i] | (seen[i] & head_sel[i]);
  end

  assign multi_sel = dup[HEADS];

endmodule : head_count

// *** disk_ctrl_model.sv ***
/*
  Controller model: drives gates, seek, return-to-zero and fault clear.
  Assumes the bench calls its tasks from one process, on clk.
*/
`timescale 1ns/1ps
module disk_ctrl_model
(
  // Clock and drive status
  input  wire logic  clk,
  input  wire logic  seek_error_line,
  input  wire logic  auto_rtz,
  // Commands to the drive
  output logic       read_gate,
  output logic       write_gate,
  output logic       seek_start,
  output logic [9:0] seek_cyl,
  output logic       rtz_cmd,
  output logic       ctrl_clear
);
  initial
  begin
    {read_gate, write_gate, seek_start, rtz_cmd, ctrl_clear} = 5'h00;
    seek_cyl = 10'h000;
  end
  // Only a return-to-zero seek recovers; one pulse, then wait for the drop
  always @(posedge clk)
    rtz_cmd <= auto_rtz & seek_error_line & ~rtz_cmd;
  task automatic seek(input logic [9:0] cyl);
    @(posedge clk);
    seek_start <= 1'b1;
    seek_cyl   <= cyl;
    @(posedge clk);
    seek_start <= 1'b0;
    seek_cyl   <= ~cyl; // Address no longer qualified
  endtask : seek
  task automatic gates(input logic r, input logic w);
    @(posedge clk);
    read_gate  <= r;
    write_gate <= w;
  endtask : gates
  task automatic clear;
    @(posedge clk);
    ctrl_clear <= 1'b1;
    @(posedge clk);
    ctrl_clear <= 1'b0;
  endtask : clear
endmodule : disk_ctrl_model

// *** testbench.sv ***
/*
  Self-checking bench for the fault and error detection block.
  Assumes short timeout parameters; the controller model drives gates.
*/
`timescale 1ns/1ps
module testbench;
  localparam int SRV = 50;
  localparam int SKC = 80;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  fault_pkg::write_mon_type wm = '0;
  logic supply_low = 0, speed_low = 0, large_variant = 0, on_cyl = 1;
  logic travel = 0, load_start = 0, dibit = 0, op_sw = 0, maint_sw = 0;
  logic auto_rtz = 0, reg_wr = 0, reg_rd = 0;
  logic [18:0] head_sel = 19'h00001;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, rd_v;
  logic rg, wg, sk, rtz, cclr, irq, f_line, lamp, ready, se_line, wp;
  logic w_inh, l_inh, s_inh, emr, home, s_acc;
  logic [9:0] cyl;
  logic [31:0] rs = 32'h1d5a;
  int n_fail = 0, compares = 0, ind_m = 0;
  logic [7:0] rdata;

  always #12.5 clk = ~clk;

  disk_ctrl_model i_ctrl (.clk(clk), .seek_error_line(se_line), .auto_rtz(auto_rtz),
    .read_gate(rg), .write_gate(wg), .seek_start(sk), .seek_cyl(cyl), .rtz_cmd(rtz),
    .ctrl_clear(cclr));

  drive_fault_error_detect #(.SERVO_CYC(SRV), .SEEK_CYC(SKC)) i_dut (
    .clk(clk), .rst_b(rst_b), .write_mon(wm), .supply_low(supply_low),
    .speed_low(speed_low), .head_sel(head_sel), .read_gate(rg), .write_gate(wg),
    .seek_start(sk), .seek_cyl(cyl), .rtz_cmd(rtz), .large_variant(large_variant),
    .on_cylinder(on_cyl), .travel_limit_sensed(travel), .load_start(load_start),
    .dibit_seen(dibit), .clear_src({op_sw, cclr, maint_sw}), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .irq(irq), .fault_line(f_line), .fault_lamp(lamp), .unit_ready(ready),
    .seek_error_line(se_line), .write_protect(wp), .write_inhibit(w_inh),
    .load_inhibit(l_inh), .seek_inhibit(s_inh), .emergency_retract(emr),
    .home_retract_logic(home), .seek_accept(s_acc));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk_bit(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %b", $time, m, got);
    end
  endtask : chk_bit
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_reg
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = rdata;
  endtask : rd
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic pulse_sw(input int s);
    @(posedge clk);
    if (s == 0) op_sw <= 1'b1; else maint_sw <= 1'b1;
    @(posedge clk);
    {op_sw, maint_sw} <= 2'b00;
  endtask : pulse_sw
  task automatic err(input int k, input logic on);
    @(posedge clk);
    if (k < 4) wm[3-k] <= on;
    if (k == 4) head_sel <= on ? 19'h00041 : 19'h00001;
    if (k == 6) on_cyl <= ~on;
    if (k == 7) supply_low <= on;
    if (k == 5 || k == 6) i_ctrl.gates(on, k == 5 && on);
  endtask : err
  task automatic chk_fault(input logic e);
    chk_bit(f_line, e, "fault line");
    chk_bit(ready, ~e, "unit ready");
    chk_bit(lamp, e, "lamp");
    chk_bit(w_inh, e, "write inhibit");
    chk_bit(l_inh, e, "load inhibit");
  endtask : chk_fault
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial
  begin
    #500us;
    n_fail++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin : main
    int bits[8];
    logic [18:0] hs;
    bits = '{0, 0, 0, 0, 1, 2, 3, 4};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    chk_fault(1'b0);
    rd(2'h2);
    chk_reg(rd_v, 8'h00, "ind reset");
    for (int k = 0; k < 8; k++)
    begin
      err(k, 1'b1);
      cyc(3);
      ind_m = ind_m | (1 << bits[k]);
      chk_fault(1'b1);
      rd(2'h2);
      chk_reg(rd_v, ind_m[7:0], "ind set");
      pulse_sw(0);
      cyc(3);
      chk_bit(f_line, 1'b1, "clear with error");
      err(k, 1'b0);
      cyc(3);
      if (k % 3 == 1) i_ctrl.clear(); else pulse_sw(k % 3 == 0 ? 0 : 1);
      if (k % 3 == 2) ind_m = 0;
      cyc(3);
      chk_fault(1'b0);
      rd(2'h2);
      chk_reg(rd_v, ind_m[7:0], "ind after clear");
    end
    for (int i = 0; i < 8; i++)
    begin
      rs = xs();
      hs = (19'h1 << (rs % 19)) | (rs[5] ? 19'h1 << ((rs >> 8) % 19) : 19'h0);
      head_sel <= hs;
      cyc(3);
      chk_bit(f_line, $countones(hs) > 1, "head select");
      if ($countones(hs) > 1) ind_m = ind_m | 2;
      head_sel <= 19'h00001;
      pulse_sw(0);
      cyc(2);
    end
    rd(2'h0);
    wr(2'h1, 8'h01);
    wr(2'h2, 8'hff);
    rd(2'h1);
    chk_reg(rd_v, 8'h01, "mask");
    rd(2'h2);
    chk_reg(rd_v, ind_m[7:0], "ind not writable");
    speed_low <= 1'b1;
    cyc(3);
    chk_bit(wp, 1'b1, "write protect");
    chk_bit(emr, 1'b1, "retract");
    chk_bit(f_line, 1'b0, "no fault");
    chk_bit(irq, 1'b0, "masked irq");
    speed_low <= 1'b0;
    rd(2'h0);
    chk_reg(rd_v, 8'h10, "status speed");
    err(5, 1'b1);
    cyc(3);
    chk_bit(irq, 1'b1, "irq");
    rd(2'h0);
    chk_reg(rd_v, 8'h01, "status fault");
    cyc(1);
    chk_bit(irq, 1'b0, "irq cleared");
    err(5, 1'b0);
    pulse_sw(0);
    cyc(2);
    dibit <= 1'b0;
    load_start <= 1'b1;
    cyc(1);
    load_start <= 1'b0;
    cyc(SRV - 10);
    load_start <= 1'b1;
    cyc(1);
    load_start <= 1'b0;
    cyc(SRV - 10);
    chk_bit(home, 1'b0, "timer restart");
    cyc(14);
    chk_bit(home, 1'b1, "no servo");
    chk_bit(lamp, 1'b1, "no servo lamp");
    chk_bit(l_inh, 1'b1, "load refused");
    chk_bit(f_line, 1'b0, "no servo no fault");
    i_ctrl.clear();
    cyc(3);
    chk_bit(home, 1'b0, "no servo cleared");
    load_start <= 1'b1;
    cyc(1);
    load_start <= 1'b0;
    dibit <= 1'b1;
    cyc(SRV + 5);
    chk_bit(home, 1'b0, "servo found");
    i_ctrl.seek(10'h064);
    on_cyl <= 1'b0;
    cyc(SKC - 20);
    on_cyl <= 1'b1;
    cyc(25);
    chk_bit(se_line, 1'b0, "seek in time");
    i_ctrl.seek(10'h064);
    on_cyl <= 1'b0;
    cyc(SKC + 4);
    chk_bit(se_line, 1'b1, "seek timeout");
    chk_bit(s_inh, 1'b1, "seek refused");
    on_cyl <= 1'b1;
    auto_rtz <= 1'b1;
    cyc(4);
    chk_bit(se_line, 1'b0, "rtz clears");
    for (int j = 0; j < 4; j++)
    begin
      auto_rtz <= 1'b0;
      large_variant <= j[1];
      i_ctrl.seek((j[1] ? fault_pkg::CYL_MAX_LARGE : fault_pkg::CYL_MAX_SMALL) + j[0]);
      cyc(3);
      chk_bit(se_line, j[0], "cylinder limit");
      auto_rtz <= 1'b1;
      cyc(4);
    end
    auto_rtz <= 1'b0;
    travel <= 1'b1;
    cyc(3);
    chk_bit(se_line, 1'b1, "travel limit");
    travel <= 1'b0;
    auto_rtz <= 1'b1;
    cyc(4);
    chk_bit(se_line, 1'b0, "travel rtz");
    complete_run();
  end
endmodule : testbench
